/* see_abn_decoder.sv */
`timescale 1ns/1ns
module see_abn_decoder (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   // encoder inputs and setup
   input  wire see_pkg::see_abn_t     pins,
   input  wire see_pkg::see_abn_cfg_t cfg,
   input  wire see_pkg::see_abn_wr_t  wr,
   // decoded state
   output see_pkg::see_abn_st_t       st
);

   logic [1:0]  ab_q, ab_d;
   logic        n_q, n_d;
   logic [15:0] cnt_q, cnt_d, npos_q, npos_d;
   logic        nval_q, nval_d;
   logic        prime_q;
   logic [31:0] multi_q, multi_d;
   logic        a, b, n, idx, up, dn;
   logic [15:0] last;

   // polarity, qualification and quadrature step decode
   always_comb begin
      a    = pins.a ^ cfg.pol_a;
      b    = pins.b ^ cfg.pol_b;
      n    = pins.n ^ cfg.pol_n;
      last = cfg.cpr - 16'h0001;
      idx  = cfg.use_nab ? (n & a & b) : n;
      // gray step: forward when new a equals old b inverted relation
      up   = (ab_q == 2'b00 && {a, b} == 2'b10) || (ab_q == 2'b10 && {a, b} == 2'b11) ||
             (ab_q == 2'b11 && {a, b} == 2'b01) || (ab_q == 2'b01 && {a, b} == 2'b00);
      dn   = (ab_q == 2'b00 && {a, b} == 2'b01) || (ab_q == 2'b01 && {a, b} == 2'b11) ||
             (ab_q == 2'b11 && {a, b} == 2'b10) || (ab_q == 2'b10 && {a, b} == 2'b00);
      if (cfg.dir) begin
         {up, dn} = {dn, up};
      end
      // first edge after reset only learns the pin levels, so no false step
      up   = up & prime_q;
      dn   = dn & prime_q;
   end

   // modulo counter, index handling and multi-turn extension
   always_comb begin
      ab_d    = {a, b};
      n_d     = idx;
      cnt_d   = cnt_q;
      npos_d  = npos_q;
      nval_d  = nval_q;
      multi_d = multi_q;
      if (up) begin
         cnt_d   = (cnt_q >= last) ? 16'h0000 : cnt_q + 16'h0001;
         multi_d = multi_q + 32'h0000_0001;
      end else if (dn) begin
         cnt_d   = (cnt_q == 16'h0000) ? last : cnt_q - 16'h0001;
         multi_d = multi_q - 32'h0000_0001;
      end
      if (idx && !n_q && prime_q) begin
         if ((cfg.n_reload || cfg.n_writeback) && nval_q) begin
            cnt_d = npos_q;
         end else begin
            npos_d = cnt_q;
            nval_d = 1'b1;
         end
      end
      if (wr.wr_count) begin
         cnt_d = wr.count;
      end
      if (wr.wr_multi) begin
         multi_d = wr.multi;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ab_q    <= 2'h0;
         n_q     <= 1'b0;
         cnt_q   <= 16'h0000;
         npos_q  <= 16'h0000;
         nval_q  <= 1'b0;
         multi_q <= 32'h0000_0000;
         prime_q <= 1'b0;
      end else begin
         ab_q    <= ab_d;
         n_q     <= n_d;
         cnt_q   <= cnt_d;
         npos_q  <= npos_d;
         nval_q  <= nval_d;
         multi_q <= multi_d;
         prime_q <= 1'b1;
      end
   end

   // scaled angle: count * 65536 / cpr
   always_comb begin
      st.count   = cnt_q;
      st.n_pos   = npos_q;
      st.n_valid = nval_q;
      st.multi   = multi_q;
      st.phi     = (cfg.cpr == 16'h0000) ? 16'h0000 :
                   16'(({cnt_q, 16'h0000}) / {16'h0000, cfg.cpr});
   end

endmodule : see_abn_decoder

/* see_encoder_engine.sv */
`timescale 1ns/1ns
// Summary of operation
// - deliver 16-bit electrical and mechanical angles
// - multi-turn extension, software may overwrite
// - selection picks commutation angle source
// - selection picks velocity source; phi_m and abn2 sources not pole scaled
// - open loop ramps speed, applies d voltage
// - open loop direction bit reverses motion
// - abn counter modulo counts per revolution
// - software may load counter while counting
// - electrical and multi-turn positions writable
// - pole pairs and offsets set angles
// - index captures count or reloads it
// - index alone or and-ed with a,b
// - polarity per index, a, b input
// - captured index written back every index
// - abn direction bit inverts counting
// - secondary decoder never drives commutation
// - hall state maps to angle plus offset
// - hall angles default, software replaceable
// - hall gives 60 degree absolute steps
// - hall interpolation only above 60 rpm
// - external position is selectable commutation source
module see_encoder_engine (
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rstn,
   // encoder and hall pins
   input  wire see_pkg::see_abn_t     abn_pins,
   input  wire see_pkg::see_abn_t     abn2_pins,
   input  wire logic [2:0]            hall_pins,
   // abn setup and software writes
   input  wire see_pkg::see_abn_cfg_t abn_cfg,
   input  wire see_pkg::see_abn_cfg_t abn2_cfg,
   input  wire see_pkg::see_abn_wr_t  abn_wr,
   input  wire see_pkg::see_abn_wr_t  abn2_wr,
   // angle setup
   input  wire logic [7:0]            pole_pairs,
   input  wire logic [15:0]           phi_e_offset,
   input  wire logic [15:0]           phi_m_offset,
   input  wire logic [2:0]            phi_e_select,
   input  wire logic [2:0]            velocity_select,
   input  wire logic [15:0]           ext_position,
   // open loop
   input  wire logic [15:0]           ol_target_rpm,
   input  wire logic [15:0]           ol_accel_rpms,
   input  wire logic                  ol_dir,
   input  wire logic [15:0]           ol_ud_set,
   // hall setup and multi-turn write
   input  wire logic                  hall_wr,
   input  wire logic [2:0]            hall_wr_idx,
   input  wire logic [15:0]           hall_wr_angle,
   input  wire logic                  hall_interp_en,
   input  wire logic [15:0]           speed_rpm_abs,
   input  wire logic                  multi_wr,
   input  wire logic [31:0]           multi_wr_val,
   // angles, open-loop, hall and decoder status out
   output logic [15:0]                phi_e,
   output logic [15:0]                phi_m,
   output logic [15:0]                velocity_angle,
   output logic [31:0]                multi_turn,
   output logic [15:0]                openloop_direct_axis_voltage,
   output logic [15:0]                ol_phi,
   output logic [15:0]                ol_speed,
   output logic [15:0]                hall_phi,
   output logic                       hall_interp_active,
   output see_pkg::see_abn_st_t       abn_state,
   output see_pkg::see_abn_st_t       abn2_state
);

   see_pkg::see_abn_st_t abn_st, abn2_st;

   see_abn_decoder u_abn (
      .mclk (mclk),
      .rstn (rstn),
      .pins (abn_pins),
      .cfg  (abn_cfg),
      .wr   (abn_wr),
      .st   (abn_st)
   );

   // secondary feeds velocity and position only
   see_abn_decoder u_abn2 (
      .mclk (mclk),
      .rstn (rstn),
      .pins (abn2_pins),
      .cfg  (abn2_cfg),
      .wr   (abn2_wr),
      .st   (abn2_st)
   );

   // ---- open loop generator ----
   logic [15:0] div_q, div_d;
   logic        tick;
   logic [15:0] olv_q, olv_d;
   logic [31:0] olacc_q, olacc_d;
   logic [15:0] acc_frac_q, acc_frac_d;

   // update-rate divider, one pulse each update period
   // a free-running divider keeps every update tick exactly one clock wide
   always_comb begin
      tick  = (div_q == see_pkg::OL_DIV_LAST);
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
   end

   // velocity ramp and angle integration; speed in rpm, 1/10000 s steps
   always_comb begin
      olv_d      = olv_q;
      acc_frac_d = acc_frac_q;
      olacc_d    = olacc_q;
      if (tick) begin
         acc_frac_d = acc_frac_q + ol_accel_rpms;
         if (acc_frac_d >= 16'h2710) begin
            acc_frac_d = acc_frac_d - 16'h2710;
            if (olv_q < ol_target_rpm) begin
               olv_d = olv_q + 16'h0001;
            end
         end
         if (olv_q > ol_target_rpm) begin
            olv_d = ol_target_rpm;
         end
         // rpm to electrical angle per update
         if (ol_dir) begin
            olacc_d = olacc_q - ({16'h0000, olv_q} * 32'h0000_0007);
         end else begin
            olacc_d = olacc_q + ({16'h0000, olv_q} * 32'h0000_0007);
         end
      end
   end

   // open-loop state registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div_q      <= 16'h0000;
         olv_q      <= 16'h0000;
         olacc_q    <= 32'h0000_0000;
         acc_frac_q <= 16'h0000;
      end else begin
         div_q      <= div_d;
         olv_q      <= olv_d;
         olacc_q    <= olacc_d;
         acc_frac_q <= acc_frac_d;
      end
   end

   // ---- hall decoder ----
   logic [15:0] hall_tab_q [6];
   logic [15:0] hall_tab_d [6];
   logic [2:0]  hall_prev_q;
   logic [15:0] hall_raw;
   logic [2:0]  hall_idx;

   // map hall vector 1..6 to sector index
   function automatic logic [2:0] hall_sector(input logic [2:0] h);
      case (h)
         3'h5:    hall_sector = 3'h0;
         3'h4:    hall_sector = 3'h1;
         3'h6:    hall_sector = 3'h2;
         3'h2:    hall_sector = 3'h3;
         3'h3:    hall_sector = 3'h4;
         3'h1:    hall_sector = 3'h5;
         default: hall_sector = 3'h7;
      endcase
   endfunction : hall_sector

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         hall_tab_d[i] = hall_tab_q[i];
      end
      if (hall_wr && hall_wr_idx < 3'h6) begin
         hall_tab_d[hall_wr_idx] = hall_wr_angle;
      end
   end

   // table returns to its defaults only on reset; writes persist until then
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hall_tab_q[0] <= see_pkg::HALL_DEF_0;
         hall_tab_q[1] <= see_pkg::HALL_DEF_1;
         hall_tab_q[2] <= see_pkg::HALL_DEF_2;
         hall_tab_q[3] <= see_pkg::HALL_DEF_3;
         hall_tab_q[4] <= see_pkg::HALL_DEF_4;
         hall_tab_q[5] <= see_pkg::HALL_DEF_5;
         hall_prev_q   <= 3'h0;
      end else begin
         for (int i = 0; i < 6; i++) begin
            hall_tab_q[i] <= hall_tab_d[i];
         end
         hall_prev_q <= hall_pins;
      end
   end

   // 60 degree absolute steps; invalid vectors hold zero
   always_comb begin
      hall_idx = hall_sector(hall_pins);
      hall_raw = (hall_idx < 3'h6) ? hall_tab_q[hall_idx] : 16'h0000;
   end

   // interpolation within a sector from an elapsed-time estimate
   // limitation: the estimate trusts speed_rpm_abs to be already filtered
   logic [15:0] interp_q, interp_d;
   logic        interp_on;
   always_comb begin
      interp_on = hall_interp_en && (speed_rpm_abs > see_pkg::HALL_INTERP_MIN_RPM);
      interp_d  = interp_q;
      if (hall_pins != hall_prev_q || !interp_on) begin
         interp_d = 16'h0000;
      end else if (tick && interp_q < 16'h2a00) begin
         // bounded below one sector so angle never passes next edge
         interp_d = interp_q + 16'(speed_rpm_abs * 16'h0007);
         if (interp_d > 16'h2a00) begin
            interp_d = 16'h2a00;
         end
      end
   end

   // interpolation offset register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         interp_q <= 16'h0000;
      end else begin
         interp_q <= interp_d;
      end
   end

   // ---- angle selection and outputs ----
   // the secondary decoder is deliberately absent from the commutation case
   logic [15:0] phi_e_d, phi_m_d, vel_d, hall_phi_d;
   logic [31:0] multi_d, multi_q;
   always_comb begin
      hall_phi_d = hall_raw + (interp_on ? interp_q : 16'h0000) + phi_e_offset;
      case (phi_e_select)
         see_pkg::SEL_OPENLOOP: phi_e_d = olacc_q[31:16];
         see_pkg::SEL_ABN:      phi_e_d = 16'(abn_st.phi * pole_pairs) + phi_e_offset;
         see_pkg::SEL_HALL:     phi_e_d = hall_phi_d;
         see_pkg::SEL_EXT:      phi_e_d = ext_position;
         default:               phi_e_d = 16'h0000;
      endcase
      phi_m_d = abn_st.phi + phi_m_offset;
      case (velocity_select)
         see_pkg::VSEL_PHI_E: vel_d = phi_e_d;
         see_pkg::VSEL_PHI_M: vel_d = phi_m_d;
         see_pkg::VSEL_ABN2:  vel_d = abn2_st.phi;
         see_pkg::VSEL_HALL:  vel_d = hall_phi_d;
         default:             vel_d = phi_e_d;
      endcase
      // multi-turn follows turn wrap, software overwrite
      // quadrant test tolerates phi_m jumps of up to a quarter turn per clock
      multi_d = multi_q;
      if (multi_wr) begin
         multi_d = multi_wr_val;
      end else if (phi_m_d[15:14] == 2'b00 && phi_m[15:14] == 2'b11) begin
         multi_d = multi_q + 32'h0001_0000;
      end else if (phi_m_d[15:14] == 2'b11 && phi_m[15:14] == 2'b00) begin
         multi_d = multi_q - 32'h0001_0000;
      end
      multi_d = {multi_d[31:16], phi_m_d};
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phi_e                        <= 16'h0000;
         phi_m                        <= 16'h0000;
         velocity_angle               <= 16'h0000;
         multi_q                      <= 32'h0000_0000;
         openloop_direct_axis_voltage <= 16'h0000;
         ol_phi                       <= 16'h0000;
         ol_speed                     <= 16'h0000;
         hall_phi                     <= 16'h0000;
         hall_interp_active           <= 1'b0;
         abn_state                    <= '0;
         abn2_state                   <= '0;
      end else begin
         phi_e                        <= phi_e_d;
         phi_m                        <= phi_m_d;
         velocity_angle               <= vel_d;
         multi_q                      <= multi_d;
         // d voltage only applied in open loop
         openloop_direct_axis_voltage <= (phi_e_select == see_pkg::SEL_OPENLOOP) ?
                                         ol_ud_set : 16'h0000;
         ol_phi                       <= olacc_q[31:16];
         ol_speed                     <= olv_q;
         hall_phi                     <= hall_phi_d;
         hall_interp_active           <= interp_on;
         abn_state                    <= abn_st;
         abn2_state                   <= abn2_st;
      end
   end

   // multi_q is itself the flop, so the output stays registered
   assign multi_turn = multi_q;

endmodule : see_encoder_engine

/* see_encoder_engine_props.sv */
`timescale 1ns/1ns
module see_encoder_engine_props (
   // clock and reset
   input wire logic                  mclk,
   input wire logic                  rstn,
   // watched inputs
   input wire see_pkg::see_abn_cfg_t abn_cfg,
   input wire see_pkg::see_abn_cfg_t abn2_cfg,
   input wire see_pkg::see_abn_wr_t  abn_wr,
   input wire logic [7:0]            pole_pairs,
   input wire logic [15:0]           phi_e_offset,
   input wire logic [2:0]            phi_e_select,
   input wire logic [15:0]           ext_position,
   input wire logic [15:0]           ol_ud_set,
   input wire logic                  hall_interp_en,
   input wire logic [15:0]           speed_rpm_abs,
   // watched outputs
   input wire logic [15:0]           phi_e,
   input wire logic [15:0]           openloop_direct_axis_voltage,
   input wire logic [15:0]           hall_phi,
   input wire logic                  hall_interp_active,
   input wire see_pkg::see_abn_st_t  abn_state,
   input wire see_pkg::see_abn_st_t  abn2_state
);
   // angle checks wait until every cause has sat still, so pipeline depth cannot fool them
   logic [91:0] snap_q, snap_d;
   logic [1:0]  calm_q, calm_d;

   // next snapshot and calm count
   always_comb begin
      snap_d = {abn_state.count, abn_cfg.cpr, pole_pairs, phi_e_offset, phi_e_select,
                ext_position, hall_phi, hall_interp_en};
      calm_d = (snap_d != snap_q) ? 2'h0 : (calm_q == 2'h3) ? 2'h3 : calm_q + 2'h1;
   end

   // register snapshot and calm count
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         snap_q <= '0;
         calm_q <= 2'h0;
      end else begin
         snap_q <= snap_d;
         calm_q <= calm_d;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   AST_OL_UD: assert property ($past(rstn) |-> openloop_direct_axis_voltage ==
      (($past(phi_e_select) == see_pkg::SEL_OPENLOOP) ? $past(ol_ud_set) : 16'h0000))
      else $error("open-loop voltage does not follow selection");
   AST_WR_COUNT: assert property (abn_wr.wr_count |=> ##1
      abn_state.count == $past(abn_wr.count, 2)) else $error("count load lost");
   AST_ABN_RANGE: assert property ($stable(abn_cfg.cpr) && abn_cfg.cpr != 16'h0000
      |-> abn_state.count < abn_cfg.cpr) else $error("count outside modulo range");
   AST_ABN2_RANGE: assert property ($stable(abn2_cfg.cpr) && abn2_cfg.cpr != 16'h0000
      |-> abn2_state.count < abn2_cfg.cpr) else $error("second count outside range");
   AST_ABN_PHI: assert property (calm_q == 2'h3 && abn_cfg.cpr != 16'h0000 |->
      abn_state.phi == 16'(({16'h0000, abn_state.count} << 16) / abn_cfg.cpr))
      else $error("decoder angle not scaled to a full turn");
   AST_SEL_ABN: assert property (calm_q == 2'h3 && phi_e_select == see_pkg::SEL_ABN
      |-> phi_e == 16'(abn_state.phi * pole_pairs + phi_e_offset))
      else $error("commutation angle from encoder wrong");
   AST_SEL_EXT: assert property (calm_q == 2'h3 && phi_e_select == see_pkg::SEL_EXT
      && phi_e_offset == 16'h0000 |-> phi_e == ext_position)
      else $error("external position not selected");
   AST_SEL_HALL: assert property (calm_q == 2'h3 && phi_e_select == see_pkg::SEL_HALL
      && !hall_interp_en && phi_e_offset == 16'h0000 |-> phi_e == hall_phi)
      else $error("hall angle not selected");
   AST_INTERP: assert property (hall_interp_active |-> ($past(hall_interp_en)
      || $past(hall_interp_en, 2)) && ($past(speed_rpm_abs) > see_pkg::HALL_INTERP_MIN_RPM
      || $past(speed_rpm_abs, 2) > see_pkg::HALL_INTERP_MIN_RPM))
      else $error("interpolation active when not allowed");
endmodule : see_encoder_engine_props

bind see_encoder_engine see_encoder_engine_props u_props (.*);

/* see_motor_sensors.sv */
`timescale 1ns/1ns
module see_motor_sensors (
   // clock
   input  wire logic         mclk,
   // motion requested by the bench
   input  wire logic         run,
   input  wire logic         back,
   input  wire logic [2:0]   inv,
   // encoder lines
   output see_pkg::see_abn_t pins
);
   logic [15:0] pos = 16'h0001;
   logic [1:0]  ph  = 2'h0;

   // one quadrature step every four clocks over a sixteen-count turn
   always @(posedge mclk) begin
      if (run) begin
         ph <= ph + 2'h1;
         if (ph == 2'h3)
            pos <= back ? pos - 16'h0001 & 16'h000f : pos + 16'h0001 & 16'h000f;
      end
   end

   // gray-coded lines; index rises mid-step and falls on the same edge where a or b changes
   always_comb begin
      pins.a = pos[0] ^ pos[1] ^ inv[2];
      pins.b = pos[1] ^ inv[1];
      pins.n = (pos == 16'h0000 && ph[1]) ^ inv[0];
   end
endmodule : see_motor_sensors

/* see_pkg.sv */
package see_pkg;

   // phi_e source selection codes
   localparam logic [2:0] SEL_OPENLOOP = 3'h0;
   localparam logic [2:0] SEL_ABN      = 3'h1;
   localparam logic [2:0] SEL_HALL     = 3'h2;
   localparam logic [2:0] SEL_EXT      = 3'h3;
   // velocity / position source selection codes
   localparam logic [2:0] VSEL_PHI_E   = 3'h0;
   localparam logic [2:0] VSEL_PHI_M   = 3'h1;
   localparam logic [2:0] VSEL_ABN2    = 3'h2;
   localparam logic [2:0] VSEL_HALL    = 3'h3;

   // timing of the open-loop generator
   localparam int  CLK_MHZ        = 250;
   localparam int  OL_UPDATE_US   = 100;
   localparam int  OL_UPDATE_CYC  = CLK_MHZ * OL_UPDATE_US;
   localparam logic [15:0] OL_DIV_LAST = 16'(OL_UPDATE_CYC - 1);

   // hall interpolation threshold in rpm
   localparam logic [15:0] HALL_INTERP_MIN_RPM = 16'h003c;

   // reset values
   localparam logic [15:0] CPR_RESET  = 16'h1000;
   localparam logic [7:0]  PP_RESET   = 8'h04;

   // default hall angles per state 1..6 (60 degree steps)
   localparam logic [15:0] HALL_DEF_0 = 16'h0000;
   localparam logic [15:0] HALL_DEF_1 = 16'h2aaa;
   localparam logic [15:0] HALL_DEF_2 = 16'h5555;
   localparam logic [15:0] HALL_DEF_3 = 16'h8000;
   localparam logic [15:0] HALL_DEF_4 = 16'haaaa;
   localparam logic [15:0] HALL_DEF_5 = 16'hd555;

   typedef struct packed {
      logic a;
      logic b;
      logic n;
   } see_abn_t;

   typedef struct packed {
      logic       pol_a;
      logic       pol_b;
      logic       pol_n;
      logic       dir;
      logic       use_nab;
      logic       n_reload;
      logic       n_writeback;
      logic [15:0] cpr;
   } see_abn_cfg_t;

   typedef struct packed {
      logic        wr_count;
      logic [15:0] count;
      logic        wr_multi;
      logic [31:0] multi;
   } see_abn_wr_t;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] n_pos;
      logic        n_valid;
      logic [15:0] phi;
      logic [31:0] multi;
   } see_abn_st_t;

endpackage : see_pkg

/* test_see_encoder_engine.sv */
`timescale 1ns/1ns
module test_see_encoder_engine;
   typedef struct {logic [3:0] sel; logic [31:0] exp;} see_note_t;
   // design inputs and outputs
   logic                  mclk, rstn, ol_dir, hall_wr, hall_interp_en, multi_wr;
   logic                  run, back, hall_interp_active;
   logic [2:0]            hall_pins, phi_e_select, velocity_select, hall_wr_idx, inv;
   logic [7:0]            pole_pairs, pp;
   logic [15:0]           phi_e_offset, phi_m_offset, ext_position, ol_target_rpm, sv;
   logic [15:0]           ol_accel_rpms, ol_ud_set, hall_wr_angle, speed_rpm_abs;
   logic [15:0]           phi_e, phi_m, velocity_angle, openloop_direct_axis_voltage;
   logic [15:0]           ol_phi, ol_speed, hall_phi;
   logic [31:0]           multi_wr_val, multi_turn;
   see_pkg::see_abn_t     abn_pins, abn2_pins;
   see_pkg::see_abn_cfg_t abn_cfg, abn2_cfg;
   see_pkg::see_abn_wr_t  abn_wr, abn2_wr;
   see_pkg::see_abn_st_t  abn_state, abn2_state;
   see_note_t             notes[$];
   see_note_t             cur;
   int                    num_errors = 0;
   int                    n_compared = 0;
   logic [2:0]            hvec[6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   logic [15:0]           hdef[6] = '{see_pkg::HALL_DEF_0, see_pkg::HALL_DEF_1,
      see_pkg::HALL_DEF_2, see_pkg::HALL_DEF_3, see_pkg::HALL_DEF_4, see_pkg::HALL_DEF_5};

   see_encoder_engine uut (.*);
   see_motor_sensors enc1 (.mclk(mclk), .run(run), .back(back), .inv(inv), .pins(abn_pins));
   see_motor_sensors enc2 (.mclk(mclk), .run(run), .back(1'b0), .inv(3'h0), .pins(abn2_pins));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic note(input logic [3:0] sel, input logic [31:0] exp);
      notes.push_back('{sel, exp});
   endtask : note

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick

   function automatic logic [31:0] pick(input logic [3:0] sel);
      case (sel)
         4'h0: return 32'(phi_e);
         4'h1: return 32'(abn_state.count);
         4'h2: return {abn_state.n_valid, 15'h0000, abn_state.n_pos};
         4'h3: return 32'(hall_phi);
         4'h4: return 32'(hall_interp_active);
         4'h5: return 32'(openloop_direct_axis_voltage);
         4'h6: return 32'(ol_speed);
         4'h7: return 32'(multi_turn[31:16]);
         4'h8: return 32'(abn2_state.n_valid);
         4'ha: return 32'(velocity_angle);
         default: return 32'(abn_state.multi[31:16]);
      endcase
   endfunction : pick

   // watcher: outputs have settled by the falling edge
   always @(negedge mclk) begin
      while (notes.size() > 0) begin
         cur = notes.pop_front();
         check(pick(cur.sel), cur.exp);
      end
   end

   // move the encoder whole steps, then allow the two-edge decode latency
   task automatic move(input int steps, input logic rev);
      back <= rev;
      run <= 1'b1;
      tick(4 * steps);
      run <= 1'b0;
      tick(4);
   endtask : move

   task automatic load_count(input logic [15:0] v);
      abn_wr.count <= v;
      abn_wr.wr_count <= 1'b1;
      tick(1);
      abn_wr.wr_count <= 1'b0;
      tick(3);
   endtask : load_count

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // watchdog sized for two open-loop updates plus margin
   initial begin
      tick(70000);
      num_errors++;
      report_and_stop();
   end

   initial begin
      {rstn, ol_dir, hall_wr, hall_interp_en, multi_wr, run, back, inv} = '0;
      {phi_e_select, velocity_select, hall_wr_idx, pole_pairs, phi_e_offset} = '0;
      {phi_m_offset, ext_position, ol_target_rpm, ol_accel_rpms, ol_ud_set} = '0;
      {hall_wr_angle, speed_rpm_abs, multi_wr_val, abn_wr, abn2_wr} = '0;
      hall_pins = 3'h5;
      abn_cfg = '0;
      abn_cfg.cpr = 16'h0010;
      abn2_cfg = '0;
      abn2_cfg.cpr = 16'h0010;
      abn2_cfg.use_nab = 1'b1;
      void'($urandom(44025));
      tick(8);
      rstn <= 1'b1;
      tick(2);
      for (int i = 0; i < 4; i++) begin
         sv = 16'($urandom);
         ol_ud_set <= sv;
         phi_e_select <= 3'(i);
         phi_m_offset <= 16'($urandom);
         velocity_select <= 3'($urandom_range(3));
         tick(2);
         note(4'h5, (i == 0) ? 32'(sv) : 32'h0);
      end
      // polarity and count sense, each of four combinations
      for (int p = 0; p < 4; p++) begin
         inv <= {3{p[0]}};
         abn_cfg.pol_a <= p[0];
         abn_cfg.pol_b <= p[0];
         abn_cfg.pol_n <= p[0];
         abn_cfg.dir <= p[1];
         tick(2);
         load_count(16'h0003);
         move(21, 1'b0);
         note(4'h1, p[1] ? 32'h0e : 32'h08);
         if (p == 0)
            note(4'h2, 32'h8000_0002);
      end
      note(4'h8, 32'h0);
      {inv, abn_cfg.pol_a, abn_cfg.pol_b, abn_cfg.pol_n, abn_cfg.dir} <= '0;
      move(4, 1'b1);
      note(4'h1, 32'h0a);
      // reload and write-back each restore the captured index position
      for (int r = 0; r < 2; r++) begin
         abn_cfg.n_reload <= (r == 0);
         abn_cfg.n_writeback <= (r == 1);
         load_count(16'h0009);
         move(16, 1'b0);
         note(4'h1, 32'h04);
      end
      for (int i = 0; i < 3; i++) begin
         pp = 8'($urandom_range(8, 1));
         sv = 16'($urandom);
         phi_e_select <= see_pkg::SEL_ABN;
         pole_pairs <= pp;
         phi_e_offset <= sv;
         tick(4);
         note(4'h0, 32'(16'(16'h4000 * pp + sv)));
         sv = 16'($urandom);
         phi_e_select <= see_pkg::SEL_EXT;
         phi_e_offset <= 16'h0000;
         ext_position <= sv;
         velocity_select <= see_pkg::VSEL_PHI_E;
         tick(4);
         note(4'h0, 32'(sv));
         note(4'ha, 32'(sv));
      end
      phi_e_select <= see_pkg::SEL_HALL;
      for (int i = 0; i < 6; i++) begin
         hall_pins <= hvec[i];
         tick(4);
         note(4'h3, 32'(hdef[i]));
         note(4'h0, 32'(hdef[i]));
      end
      sv = 16'($urandom);
      phi_e_offset <= sv;
      tick(4);
      note(4'h0, 32'(16'(see_pkg::HALL_DEF_5 + sv)));
      // index 6 lies outside the table and must be ignored
      for (int w = 0; w < 2; w++) begin
         hall_wr <= 1'b1;
         hall_wr_idx <= (w == 0) ? 3'h2 : 3'h6;
         hall_wr_angle <= (w == 0) ? 16'h1234 : 16'h4321;
         tick(1);
         hall_wr <= 1'b0;
         hall_pins <= 3'h6;
         tick(4);
         note(4'h3, 32'(16'(16'h1234 + sv)));
         hall_pins <= 3'h1;
         tick(2);
      end
      hall_interp_en <= 1'b1;
      for (int s = 0; s < 3; s++) begin
         speed_rpm_abs <= see_pkg::HALL_INTERP_MIN_RPM + 16'(s);
         tick(4);
         note(4'h4, 32'(s != 0));
      end
      sv = 16'($urandom);
      multi_wr_val <= {sv, 16'h0000};
      multi_wr <= 1'b1;
      abn_wr.multi <= {sv, 16'h0000};
      abn_wr.wr_multi <= 1'b1;
      tick(1);
      {multi_wr, abn_wr.wr_multi} <= '0;
      tick(4);
      note(4'h7, 32'(sv));
      note(4'h9, 32'(sv));
      phi_e_select <= see_pkg::SEL_OPENLOOP;
      ol_target_rpm <= 16'h0001;
      ol_accel_rpms <= 16'hffff;
      tick(2 * see_pkg::OL_UPDATE_CYC + 20);
      note(4'h6, 32'h1);
      tick(2);
      report_and_stop();
   end
endmodule : test_see_encoder_engine
